/* design/sswd_pkg.sv */
package sswd_pkg;

  // ==========================================================
  // timing figures, in their own units
  // ==========================================================
  localparam int unsigned CLK_FREQ_HZ = 200_000_000;
  localparam int unsigned CLK_PERIOD_PS = 5_000;
  localparam longint unsigned RESET_HOLD_TIME_MS = 200;
  localparam longint unsigned WATCHDOG_PERIOD_MS = 1_600;
  localparam longint unsigned MR_MIN_LOW_NS = 1_000;
  localparam longint unsigned MR_GLITCH_NS = 100;
  localparam longint unsigned KICK_MIN_LEVEL_NS = 50;
  localparam longint unsigned SLOW_TICK_US = 100;

  // ==========================================================
  // derived cycle counts
  // ==========================================================
  // glitch filter: a low shorter than this is ignored
  localparam int unsigned MR_FILT_CYC =
    int'((MR_GLITCH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam int unsigned KICK_MIN_CYC =
    int'((KICK_MIN_LEVEL_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  // slow timing clock as a tick enable, one pulse per tick period
  localparam int unsigned SLOW_TICK_CYC =
    int'(SLOW_TICK_US * 1_000_000 / CLK_PERIOD_PS);
  localparam int unsigned RESET_HOLD_TICKS =
    int'(RESET_HOLD_TIME_MS * 1000 / SLOW_TICK_US);
  localparam int unsigned WATCHDOG_TICKS =
    int'(WATCHDOG_PERIOD_MS * 1000 / SLOW_TICK_US);

  // ==========================================================
  // widths and reset values
  // ==========================================================
  localparam int unsigned TICK_W = 32;
  localparam logic RST_OUT_RESET = 1'b0;
  localparam logic WDO_RESET = 1'b0;

  typedef enum logic [2:0] {
    SSWD_RST_ASSERT = 3'h1,
    SSWD_RST_HOLD = 3'h2,
    SSWD_RST_RUN = 3'h4
  } sswd_rst_state_t;

  typedef struct packed {
    logic undervoltage;
    logic manual_reset_n;
    logic watchdog_kick;
    logic kick_driven;
    logic aux_supply_sense;
  } sswd_pins_t;

endpackage

/* design/sswd_supervisor.sv */
`timescale 1ns/1ps

// ==========================================================
// supervisor: reset stretch, watchdog, aux power-fail flag
// ==========================================================
module sswd_supervisor #(
  parameter int unsigned RESET_HOLD_TICKS = sswd_pkg::RESET_HOLD_TICKS,
  parameter int unsigned WATCHDOG_TICKS = sswd_pkg::WATCHDOG_TICKS,
  parameter int unsigned SLOW_TICK_CYC = sswd_pkg::SLOW_TICK_CYC,
  parameter int unsigned MR_FILT_CYC = sswd_pkg::MR_FILT_CYC
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire sswd_pkg::sswd_pins_t pins_i,
  output logic reset_n_o,
  output logic watchdog_expired_n_o,
  output logic aux_supply_fail_n_o
);

  // ==========================================================
  // parameter checks
  // ==========================================================
  if (RESET_HOLD_TICKS < 1 || WATCHDOG_TICKS < 1 || SLOW_TICK_CYC < 1) begin : g_bad_timing
    $error("sswd_supervisor: unusable timing parameters");
  end
  // the glitch filter counter is eight bits wide
  if (MR_FILT_CYC < 1 || MR_FILT_CYC > 255) begin : g_bad_filter
    $error("sswd_supervisor: glitch filter length out of range");
  end

  // ==========================================================
  // input synchronisers
  // ==========================================================
  // all pin inputs are asynchronous to clk_i
  localparam int unsigned NPIN = 5;
  logic [NPIN-1:0] sync1_q;
  logic [NPIN-1:0] sync2_q;
  logic [NPIN-1:0] sync1_d;
  logic [NPIN-1:0] sync2_d;
  // idle value: supply low, mr high, no aux fail
  localparam logic [NPIN-1:0] SYNC_RESET = 5'h19;

  always_comb begin
    sync1_d = pins_i;
    sync2_d = sync1_q;
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync1_q <= SYNC_RESET;
      sync2_q <= SYNC_RESET;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
    end
  end

  sswd_pkg::sswd_pins_t pin_s;
  assign pin_s = sswd_pkg::sswd_pins_t'(sync2_q);

  // ==========================================================
  // terminal-count decode
  // ==========================================================
  // shared by the filter, divider, hold and watchdog counters
  function automatic logic sswd_at_last(
    input logic [sswd_pkg::TICK_W-1:0] cnt,
    input int unsigned limit
  );
    return cnt >= sswd_pkg::TICK_W'(limit - 1);
  endfunction

  // ==========================================================
  // slow tick strobe
  // ==========================================================
  logic [sswd_pkg::TICK_W-1:0] tick_cnt_q;
  logic [sswd_pkg::TICK_W-1:0] tick_cnt_d;
  logic tick;

  // one divider paces hold and watchdog, so both periods drift alike
  always_comb begin
    // free-running divider stands in for the slow oscillator
    tick = sswd_at_last(tick_cnt_q, SLOW_TICK_CYC);
    tick_cnt_d = tick ? '0 : tick_cnt_q + 1'b1;
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_d;
    end
  end

  // ==========================================================
  // manual reset glitch filter
  // ==========================================================
  logic [7:0] mr_cnt_q;
  logic [7:0] mr_cnt_d;
  logic mr_low_q;
  logic mr_low_d;

  always_comb begin
    mr_cnt_d = 8'h00;
    mr_low_d = mr_low_q;
    // pull-up keeps an open pin high, so only a driven low counts
    if (!pin_s.manual_reset_n) begin
      if (sswd_at_last(sswd_pkg::TICK_W'(mr_cnt_q), MR_FILT_CYC)) begin
        mr_low_d = 1'b1;
        mr_cnt_d = mr_cnt_q;
      end else begin
        mr_cnt_d = mr_cnt_q + 8'h01;
      end
    end else begin
      mr_low_d = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mr_cnt_q <= 8'h00;
      mr_low_q <= 1'b0;
    end else begin
      mr_cnt_q <= mr_cnt_d;
      mr_low_q <= mr_low_d;
    end
  end

  // ==========================================================
  // reset generator
  // ==========================================================
  sswd_pkg::sswd_rst_state_t rst_state_q;
  sswd_pkg::sswd_rst_state_t rst_state_d;
  logic [sswd_pkg::TICK_W-1:0] hold_cnt_q;
  logic [sswd_pkg::TICK_W-1:0] hold_cnt_d;
  logic reset_n_q;
  logic reset_n_d;
  logic rst_cause;

  // watchdog state is deliberately absent from the causes
  assign rst_cause = pin_s.undervoltage || mr_low_q;

  always_comb begin
    rst_state_d = rst_state_q;
    hold_cnt_d = hold_cnt_q;
    unique case (rst_state_q)
      sswd_pkg::SSWD_RST_ASSERT: begin
        hold_cnt_d = '0;
        if (!rst_cause) begin
          rst_state_d = sswd_pkg::SSWD_RST_HOLD;
        end
      end
      sswd_pkg::SSWD_RST_HOLD: begin
        if (rst_cause) begin
          rst_state_d = sswd_pkg::SSWD_RST_ASSERT;
        end else if (tick) begin
          // tick phase is free, so the stretch may be one tick short
          if (sswd_at_last(hold_cnt_q, RESET_HOLD_TICKS)) begin
            rst_state_d = sswd_pkg::SSWD_RST_RUN;
          end else begin
            hold_cnt_d = hold_cnt_q + 1'b1;
          end
        end
      end
      sswd_pkg::SSWD_RST_RUN: begin
        if (rst_cause) begin
          rst_state_d = sswd_pkg::SSWD_RST_ASSERT;
        end
      end
      default: begin
        rst_state_d = sswd_pkg::SSWD_RST_ASSERT;
      end
    endcase
    reset_n_d = (rst_state_d == sswd_pkg::SSWD_RST_RUN);
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_state_q <= sswd_pkg::SSWD_RST_ASSERT;
      hold_cnt_q <= '0;
      reset_n_q <= sswd_pkg::RST_OUT_RESET;
    end else begin
      rst_state_q <= rst_state_d;
      hold_cnt_q <= hold_cnt_d;
      reset_n_q <= reset_n_d;
    end
  end

  // ==========================================================
  // kick edge detector
  // ==========================================================
  logic kick_prev_q;
  logic kick_prev_d;
  logic kick_edge;

  // prev resets to the synchroniser's idle kick level, so no false edge
  always_comb begin
    kick_prev_d = pin_s.watchdog_kick;
    // kick levels of 50 ns span ten clocks, so no edge is missed
    kick_edge = pin_s.watchdog_kick ^ kick_prev_q;
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      kick_prev_q <= 1'b0;
    end else begin
      kick_prev_q <= kick_prev_d;
    end
  end

  // ==========================================================
  // watchdog timer
  // ==========================================================
  logic wd_en;
  logic [sswd_pkg::TICK_W-1:0] wd_cnt_q;
  logic [sswd_pkg::TICK_W-1:0] wd_cnt_d;
  logic wd_exp_q;
  logic wd_exp_d;

  assign wd_en = pin_s.kick_driven;

  always_comb begin
    wd_cnt_d = wd_cnt_q;
    wd_exp_d = wd_exp_q;
    if (!wd_en || kick_edge || !reset_n_q) begin
      // clear acts in the same clock, far inside the 35 ms bound
      wd_cnt_d = '0;
      wd_exp_d = 1'b0;
    end else if (tick && !wd_exp_q) begin
      if (sswd_at_last(wd_cnt_q, WATCHDOG_TICKS)) begin
        wd_exp_d = 1'b1;
      end else begin
        wd_cnt_d = wd_cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wd_cnt_q <= '0;
      wd_exp_q <= 1'b0;
    end else begin
      wd_cnt_q <= wd_cnt_d;
      wd_exp_q <= wd_exp_d;
    end
  end

  // ==========================================================
  // watchdog output
  // ==========================================================
  logic wdo_q;
  logic wdo_d;

  always_comb begin
    // undervoltage forces low; recovery releases with no stretch
    wdo_d = !pin_s.undervoltage && !wd_exp_d;
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wdo_q <= sswd_pkg::WDO_RESET;
    end else begin
      wdo_q <= wdo_d;
    end
  end

  // ==========================================================
  // aux power-fail flag and outputs
  // ==========================================================
  logic pfo_q;
  logic pfo_d;

  assign pfo_d = pin_s.aux_supply_sense;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pfo_q <= 1'b1;
    end else begin
      pfo_q <= pfo_d;
    end
  end

  assign reset_n_o = reset_n_q;
  assign watchdog_expired_n_o = wdo_q;
  assign aux_supply_fail_n_o = pfo_q;

endmodule

/* testbench/sswd_supervisor_properties.sv */
`timescale 1ns/1ps
// ==========================================================
// port checker
// ==========================================================
module sswd_supervisor_properties #(
  parameter int unsigned RESET_HOLD_TICKS = 5,
  parameter int unsigned WATCHDOG_TICKS = 8,
  parameter int unsigned SLOW_TICK_CYC = 4
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire sswd_pkg::sswd_pins_t pins_i,
  input wire logic reset_n_o,
  input wire logic watchdog_expired_n_o,
  input wire logic aux_supply_fail_n_o
);
  // bounds leave room for synchronisers and one tick of jitter
  localparam int HMAX = RESET_HOLD_TICKS * SLOW_TICK_CYC + 7;
  localparam int WMAX = WATCHDOG_TICKS * SLOW_TICK_CYC + 8;
  wire rn = reset_n_o;
  wire watchdog_expired_n = watchdog_expired_n_o;
  wire uv = pins_i.undervoltage;
  wire kd = pins_i.kick_driven;
  wire aux = pins_i.aux_supply_sense;
  logic [7:0] q_q;
  logic [7:0] ic_q;
  logic [7:0] mc_q;
  logic kp_q;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // ==========================================================
  // counters: quiet causes, idle kick, manual low
  // ==========================================================
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q_q <= 8'h00;
      ic_q <= 8'h00;
      mc_q <= 8'h00;
      kp_q <= 1'b0;
    end else begin
      q_q <= (uv || !pins_i.manual_reset_n) ? 8'h00 : q_q + 8'(q_q != 8'hFF);
      ic_q <= (!kd || !rn || kp_q != pins_i.watchdog_kick) ? 8'h00 : ic_q + 8'(ic_q != 8'hFF);
      mc_q <= pins_i.manual_reset_n ? 8'h00 : mc_q + 8'(mc_q != 8'hFF);
      kp_q <= pins_i.watchdog_kick;
    end
  end
  uv_force_a: assert property (uv |-> ##3 !rn && !watchdog_expired_n)
    else $error("undervoltage left an output high");
  mr_force_a: assert property (mc_q == 8'h1E |-> !rn)
    else $error("manual low gave no reset");
  mr_filter_a: assert property ($fell(rn) |-> mc_q >= 8'h12 || $past(uv, 3))
    else $error("short manual low gave reset");
  hold_max_a: assert property (q_q == HMAX |-> rn)
    else $error("reset held too long");
  no_wd_reset_a: assert property (q_q > 8'h05 && rn |=> rn)
    else $error("reset without cause");
  wd_expire_a: assert property (ic_q == WMAX |-> !watchdog_expired_n)
    else $error("watchdog did not expire");
  wd_sticky_a: assert property ($rose(watchdog_expired_n) && rn |-> ic_q <= 8'h06)
    else $error("expiry released without kick");
  uv_release_a: assert property ($fell(uv) ##1 !uv [*3] |-> watchdog_expired_n)
    else $error("watchdog output late after recovery");
  wd_off_a: assert property (!kd [*8] |-> watchdog_expired_n || !rn)
    else $error("disabled watchdog expired");
  aux_flag_a: assert property ($changed(aux) |-> ##3 aux_supply_fail_n_o == $past(aux, 3))
    else $error("power fail flag wrong");
  cover property ($fell(watchdog_expired_n) && rn);
  cover property ($rose(rn));
  cover property ($rose(watchdog_expired_n) && rn);
  cover property ($fell(aux_supply_fail_n_o));
endmodule

/* testbench/sswd_host_model.sv */
`timescale 1ns/1ps
// ==========================================================
// host: toggles the kick pin while running
// ==========================================================
module sswd_host_model #(
  parameter int GAP = 12
) (
  input wire logic clk_i,
  input wire logic run_i,
  output logic kick_o
);
  int cnt = 0;
  initial kick_o = 1'b0;
  // each level lasts GAP cycles, above the 10-cycle minimum
  always @(negedge clk_i) begin
    cnt <= (run_i && cnt < GAP - 1) ? cnt + 1 : 0;
    if (run_i && cnt == GAP - 1) begin
      kick_o <= ~kick_o;
    end
  end
endmodule

/* testbench/sswd_supervisor_bench.sv */
`timescale 1ns/1ps
// ==========================================================
// bench with shortened tick and period counts
// ==========================================================
module sswd_supervisor_bench;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic uv = 1'b1;
  logic mr = 1'b1;
  logic kd = 1'b1;
  logic aux = 1'b1;
  logic run = 1'b0;
  logic kick;
  logic reset_n;
  logic watchdog_expired_n;
  logic fail_n;
  int errors = 0;
  int samples_checked = 0;
  sswd_pkg::sswd_pins_t pins;
  assign pins = {uv, mr, kick, kd, aux};
  always #2.5 clk_i = ~clk_i;
  sswd_host_model host (.clk_i(clk_i), .run_i(run), .kick_o(kick));
  sswd_supervisor #(.RESET_HOLD_TICKS(5), .WATCHDOG_TICKS(8), .SLOW_TICK_CYC(4),
    .MR_FILT_CYC(20)) dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .pins_i(pins),
    .reset_n_o(reset_n), .watchdog_expired_n_o(watchdog_expired_n), .aux_supply_fail_n_o(fail_n));
  task automatic conclude();
    if (errors == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(string nm, logic exp, logic got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %b seen %b", nm, exp, got);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge clk_i);
  endtask
  // bounded wait; lo and hi frame the allowed delay in cycles
  task automatic wait_for(string nm, bit sel, logic lvl, int lo, int hi);
    int n;
    n = 0;
    while ((sel ? watchdog_expired_n : reset_n) !== lvl && n < hi) begin
      @(negedge clk_i);
      n++;
    end
    chk(nm, 1'b1, logic'(n >= lo && n < hi));
    if (n >= hi) conclude();
  endtask
  task automatic t_power();
    cyc(6);
    chk("reset", 1'b0, reset_n);
    chk("wdo", 1'b0, watchdog_expired_n);
    uv = 1'b0;
    cyc(5);
    chk("wdo", 1'b1, watchdog_expired_n);
    chk("reset", 1'b0, reset_n);
    wait_for("reset delay", 0, 1'b1, 12, 24);
  endtask
  task automatic t_manual();
    run = 1'b1;
    mr = 1'b0;
    cyc(10);
    mr = 1'b1;
    cyc(30);
    chk("reset", 1'b1, reset_n);
    mr = 1'b0;
    cyc(40);
    chk("reset", 1'b0, reset_n);
    mr = 1'b1;
    cyc(5);
    chk("reset", 1'b0, reset_n);
    wait_for("reset delay", 0, 1'b1, 12, 24);
  endtask
  task automatic t_watchdog();
    cyc(60);
    chk("wdo", 1'b1, watchdog_expired_n);
    run = 1'b0;
    wait_for("expiry delay", 1, 1'b0, 16, 45);
    chk("reset", 1'b1, reset_n);
    cyc(40);
    chk("wdo", 1'b0, watchdog_expired_n);
    run = 1'b1;
    wait_for("kick delay", 1, 1'b1, 8, 22);
    run = 1'b0;
  endtask
  task automatic t_disable();
    kd = 1'b0;
    cyc(60);
    chk("wdo", 1'b1, watchdog_expired_n);
    kd = 1'b1;
    run = 1'b1;
  endtask
  task automatic t_aux();
    aux = 1'b0;
    cyc(4);
    chk("fail flag", 1'b0, fail_n);
    aux = 1'b1;
    cyc(4);
    chk("fail flag", 1'b1, fail_n);
  endtask
  initial begin
    repeat (5) @(negedge clk_i);
    rst_b_i = 1'b1;
    t_power();
    t_manual();
    t_watchdog();
    t_disable();
    t_aux();
    conclude();
  end
endmodule
bind sswd_supervisor sswd_supervisor_properties #(.RESET_HOLD_TICKS(RESET_HOLD_TICKS),
  .WATCHDOG_TICKS(WATCHDOG_TICKS), .SLOW_TICK_CYC(SLOW_TICK_CYC)) chk (.clk_i(clk_i),
  .rst_b_i(rst_b_i), .pins_i(pins_i), .reset_n_o(reset_n_o),
  .watchdog_expired_n_o(watchdog_expired_n_o), .aux_supply_fail_n_o(aux_supply_fail_n_o));
